/* host_model.sv */
// Host model on the pointer register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Register port
	input wire logic clk_in,
	output logic [7:0] ptr_out = 8'h0,
	output logic wr_out = 1'h0,
	output logic rd_out = 1'h0,
	output logic [15:0] wd_out = 16'h0
);
	// Changes at the falling edge; released data shows its inverse
	task automatic go(logic w, r, logic [7:0] p, logic [15:0] d);
		@(negedge clk_in);
		{wr_out, rd_out, ptr_out} = {w, r, p};
		wd_out = w ? d : ~wd_out;
	endtask
endmodule // host_model
`default_nettype wire

/* limit_cmp_if.sv */
// Interface between the limit registers and the comparator
`timescale 1ns/1ps
`default_nettype none
interface limit_cmp_if;
	import temp_limit_pkg::*;
	reg16_t temp;
	reg16_t upper;
	reg16_t lower;
	logic above;
	logic below;
	modport regs (output temp, output upper, output lower, input above, input below);
	modport cmp (input temp, input upper, input lower, output above, output below);
endinterface
`default_nettype wire

/* limit_compare.sv */
// Signed comparison of the measured temperature against both limits
`timescale 1ns/1ps
`default_nettype none
`include "temp_limit_consts.svh"
module limit_compare
	import temp_limit_pkg::*;
(
	limit_cmp_if.cmp cmp
);
	// ==========================================
	// Alignment at the 0.25 degree weight
	function automatic limit_val_t align(input reg16_t v);
		align = limit_val_t'(v[`LIMIT_MSB:`LIMIT_LSB]);
	endfunction

	// Finer resolution bits are dropped so every resolution compares alike
	assign cmp.above = align(cmp.temp) > align(cmp.upper);
	assign cmp.below = align(cmp.temp) < align(cmp.lower);
endmodule // limit_compare
`default_nettype wire

/* temp_limit_compare.sv */
// Upper and lower temperature limit registers with alarm and flag logic
// Operation
// - The upper limit register sits at pointer 02h, 16 bits read/write, reset 7fe0h.
// - The lower limit register sits at pointer 03h, 16 bits read/write, reset 8000h.
// - Bits 15:5 of each limit are a two's complement value with 0.25 degree weight at bit 5.
// - Bits 4:0 of each limit read as zero and the host should write zeros there.
// - A temperature above the upper limit activates the alarm and sets the upper flag.
// - A temperature below the lower limit deactivates the alarm and sets the lower flag.
// - The alarm pin and alarm status are active high when the polarity bit is 1, else low; the code resets both to 0 whatever the polarity.
// - Writing 1 to the alarm clear bit makes the alarm inactive; that bit reads as 0.
`timescale 1ns/1ps
`default_nettype none
`include "temp_limit_consts.svh"
module temp_limit_compare
	import temp_limit_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pointer register port
	input wire logic [7:0] reg_ptr_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Measured temperature
	input wire logic [15:0] temp_in,
	input wire logic temp_valid_in,
	// Configuration and status controls
	input wire logic alarm_polarity_bit_in,
	input wire logic alarm_clear_bit_in,
	input wire logic flags_clear_in,
	// Alarm and flags
	output logic alarm_out,
	output logic alarm_status_out,
	output logic upper_limit_flag_out,
	output logic lower_limit_flag_out
);
	// ==========================================
	// Limit registers
	reg16_t upper_q;
	reg16_t lower_q;
	reg16_t temp_q;
	alarm_state_t alarm_q;
	alarm_state_t alarm_d;
	logic upper_flag_q;
	logic lower_flag_q;
	limit_cmp_if cmp_bus ();

	// ==========================================
	// Pointer decoding
	// One slot per limit register: slot 0 is the upper, slot 1 the lower limit
	localparam int NUM_LIMITS = 2;
	reg16_t limit_val [NUM_LIMITS];
	logic [NUM_LIMITS-1:0] wr_sel;

	// Shared by the write and the read path so both agree on the map
	function automatic logic [NUM_LIMITS-1:0] ptr_decode(input logic [7:0] ptr);
		ptr_decode = '0;
		case (ptr)
			`PTR_UPPER_LIMIT: begin
				ptr_decode = 2'h1;
			end
			`PTR_LOWER_LIMIT: begin
				ptr_decode = 2'h2;
			end
			default: begin
				ptr_decode = 2'h0;
			end
		endcase
	endfunction

	// Reset value of each slot
	function automatic reg16_t reset_value(input int idx);
		if (idx == 0) begin
			reset_value = `UPPER_LIMIT_RESET;
		end else begin
			reset_value = `LOWER_LIMIT_RESET;
		end
	endfunction

	// Writes to unknown pointers select no slot and are dropped
	assign wr_sel = reg_wr_in ? ptr_decode(reg_ptr_in) : 2'h0;

	// ==========================================
	// Limit storage
	generate
		for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_limit
			reg16_t value_q;

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					value_q <= reset_value(i);
				end else if (wr_sel[i]) begin
					// Low bits are never stored, so they always read back zero
					value_q <= reg_wdata_in & `LIMIT_MASK;
				end
			end

			assign limit_val[i] = value_q;
		end
	endgenerate

	assign upper_q = limit_val[0];
	assign lower_q = limit_val[1];

	// ==========================================
	// Read data
	// Held until the next read, so the host may sample it late
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (ptr_decode(reg_ptr_in))
				2'h1: begin
					reg_rdata_out <= upper_q;
				end
				2'h2: begin
					reg_rdata_out <= lower_q;
				end
				default: begin
					reg_rdata_out <= 16'h0000;
				end
			endcase
		end
	end

	// ==========================================
	// Latest temperature and comparison
	// Only a finished conversion is compared, never a partial value
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			temp_q <= 16'h0000;
		end else if (temp_valid_in) begin
			temp_q <= temp_in;
		end
	end

	assign cmp_bus.temp = temp_q;
	assign cmp_bus.upper = upper_q;
	assign cmp_bus.lower = lower_q;

	limit_compare u_cmp (
		.cmp(cmp_bus)
	);

	// ==========================================
	// Alarm state
	always_comb begin
		alarm_d = alarm_q;
		case (alarm_q)
			ALARM_IDLE: begin
				// A clear in the same cycle holds the alarm off for that cycle
				if (cmp_bus.above && !alarm_clear_bit_in) begin
					alarm_d = ALARM_ACTIVE;
				end
			end
			ALARM_ACTIVE: begin
				if (cmp_bus.below || alarm_clear_bit_in) begin
					alarm_d = ALARM_IDLE;
				end
			end
			default: alarm_d = ALARM_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alarm_q <= ALARM_IDLE;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	// ==========================================
	// Alarm outputs
	logic alarm_next_active;
	logic alarm_level;

	assign alarm_next_active = (alarm_d == ALARM_ACTIVE);

	// Polarity only inverts the level, the state itself stays active high
	assign alarm_level = alarm_next_active ~^ alarm_polarity_bit_in;

	// Polarity is applied at the flop so the pin never glitches
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alarm_out <= 1'b0;
		end else begin
			alarm_out <= alarm_level;
		end
	end

	// Status mirrors the pin from its own flop
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			alarm_status_out <= 1'b0;
		end else begin
			alarm_status_out <= alarm_level;
		end
	end

	// ==========================================
	// Sticky flags, a new event wins over a clear
	logic upper_event;
	logic lower_event;

	assign upper_event = cmp_bus.above;
	assign lower_event = cmp_bus.below;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			upper_flag_q <= 1'b0;
		end else begin
			upper_flag_q <= upper_event | (upper_flag_q & ~flags_clear_in);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lower_flag_q <= 1'b0;
		end else begin
			lower_flag_q <= lower_event | (lower_flag_q & ~flags_clear_in);
		end
	end

	assign upper_limit_flag_out = upper_flag_q;
	assign lower_limit_flag_out = lower_flag_q;
endmodule // temp_limit_compare
`default_nettype wire

/* temp_limit_compare_properties.sv */
// Checker on the limit block ports
`timescale 1ns/1ps
`default_nettype none
module limit_checker (
	// Watched ports
	input wire logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, flags_clear_in, alarm_out,
	input wire logic alarm_polarity_bit_in, alarm_clear_bit_in, alarm_status_out,
	input wire logic upper_limit_flag_out, lower_limit_flag_out,
	input wire logic [7:0] reg_ptr_in,
	input wire logic [15:0] reg_wdata_in, reg_rdata_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_wr(p);
		reg_wr_in && reg_ptr_in == p ##1 reg_rd_in && !reg_wr_in && reg_ptr_in == p;
	endsequence
	property p_up; s_wr(8'h2) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'hffe0); endproperty
	a_up: assert property (p_up) else $error("upper");
	property p_lo; s_wr(8'h3) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'hffe0); endproperty
	a_lo: assert property (p_lo) else $error("lower");
	property p_pad; reg_rd_in |=> reg_rdata_out[4:0] == 5'h0; endproperty
	a_pad: assert property (p_pad) else $error("pad");
	property p_oth; reg_rd_in && reg_ptr_in[7:1] != 7'h1 |=> reg_rdata_out == 16'h0; endproperty
	a_oth: assert property (p_oth) else $error("other");
	property p_stat; alarm_status_out == alarm_out; endproperty
	a_stat: assert property (p_stat) else $error("status");
	// Only checks the cycle after clear; a hot sensor may raise it again later
	property p_clr;
		alarm_clear_bit_in ##1 $stable(alarm_polarity_bit_in) |-> alarm_out ^ alarm_polarity_bit_in;
	endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_fu; upper_limit_flag_out && !flags_clear_in |=> upper_limit_flag_out; endproperty
	a_fu: assert property (p_fu) else $error("upper flag");
	property p_fl; lower_limit_flag_out && !flags_clear_in |=> lower_limit_flag_out; endproperty
	a_fl: assert property (p_fl) else $error("lower flag");
endmodule // limit_checker
bind temp_limit_compare limit_checker i_limit_checker (.*);
`default_nettype wire

/* temp_limit_compare_tb_top.sv */
// Bench for the temperature limit block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin errors++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
module temp_limit_compare_tb_top;
	import temp_limit_pkg::*;
	logic clk_in = 0, rst_n_in = 0, reg_wr_in, reg_rd_in, temp_valid_in = 0, st = 0;
	logic alarm_polarity_bit_in = 1, alarm_clear_bit_in = 0, flags_clear_in = 0;
	logic alarm_out, alarm_status_out, upper_limit_flag_out, lower_limit_flag_out;
	logic [7:0] reg_ptr_in;
	reg16_t reg_wdata_in, reg_rdata_out, temp_in = 16'h0, s = 16'hb8cb;
	localparam reg16_t up = 16'h1900, lo = 16'hf600;
	reg16_t corner[6] = '{16'h1920, 16'h191f, 16'h0, 16'hf600, 16'hf5e0, 16'h1900};
	wire logic [3:0] obs = {alarm_out, alarm_status_out, upper_limit_flag_out, lower_limit_flag_out};
	int errors = 0, checks_done = 0;
	always #5 clk_in = ~clk_in;
	host_model i_host_model (.clk_in, .ptr_out(reg_ptr_in), .wr_out(reg_wr_in),
		.rd_out(reg_rd_in), .wd_out(reg_wdata_in));
	temp_limit_compare i_temp_limit_compare (.*);
	function automatic reg16_t rnd();
		s ^= s << 7;
		s ^= s >> 9;
		s ^= s << 8;
		return s;
	endfunction
	task automatic rw(logic [7:0] p, reg16_t d, e, logic w);
		if (w) i_host_model.go(1, 0, p, d);
		i_host_model.go(0, 1, p, 16'h0);
		i_host_model.go(0, 0, p, 16'h0);
		`CHK("limit", e, reg_rdata_out)
	endtask
	task automatic step(reg16_t v, logic c);
		logic u, l, a;
		@(negedge clk_in);
		{temp_in, temp_valid_in, alarm_polarity_bit_in} = {v, 1'b1, s[3]};
		@(negedge clk_in);
		temp_valid_in = 0;
		repeat (2) @(negedge clk_in);
		{flags_clear_in, alarm_clear_bit_in} = {1'b1, c};
		@(negedge clk_in);
		{flags_clear_in, alarm_clear_bit_in} = 2'h0;
		@(negedge clk_in);
		u = $signed(v[15:5]) > $signed(up[15:5]);
		l = $signed(v[15:5]) < $signed(lo[15:5]);
		st = !l && (u || (st && !c));
		a = st ~^ alarm_polarity_bit_in;
		`CHK("alarm flags", {a, a, u, l}, obs)
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1;
		rw(8'h02, 16'h0, 16'h7fe0, 0);
		rw(8'h03, 16'h0, 16'h8000, 0);
		rw(8'h04, 16'h0, 16'h0, 0);
		repeat (20) begin
			void'(rnd());
			rw(8'h02 + s[0], s, s & 16'hffe0, 1);
		end
		rw(8'h02, up, up, 1);
		rw(8'h03, lo, lo, 1);
		$display("registers done");
		foreach (corner[i]) step(corner[i], i == 2);
		repeat (40) begin
			void'(rnd());
			step(s, s[5]);
		end
		$display("alarm done");
		report_and_stop();
	end
endmodule // temp_limit_compare_tb_top
`default_nettype wire

/* temp_limit_consts.svh */
// Offsets, field positions and reset values of the temperature limit block
`ifndef TEMP_LIMIT_CONSTS_SVH
`define TEMP_LIMIT_CONSTS_SVH

// ==========================================
// Pointer values
`define PTR_UPPER_LIMIT 8'h02
`define PTR_LOWER_LIMIT 8'h03

// ==========================================
// Reset values
`define UPPER_LIMIT_RESET 16'h7fe0
`define LOWER_LIMIT_RESET 16'h8000

// ==========================================
// Field layout
`define LIMIT_MSB 15
`define LIMIT_LSB 5
`define LIMIT_MASK 16'hffe0

`endif

/* temp_limit_pkg.sv */
// Types shared by the temperature limit block
package temp_limit_pkg;
	typedef logic [15:0] reg16_t;
	typedef logic signed [10:0] limit_val_t;
	typedef enum logic [1:0] {
		ALARM_IDLE,
		ALARM_ACTIVE
	} alarm_state_t;
endpackage
